// file: pir_far_model.sv
// far side of the routing block: peripheral event sources and the core
// assumes the bench strobes fire_i for one cycle per event
module pir_far_model
  import pir_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire logic fire_i, // event strobe
  input wire logic [4:0] fire_idx_i, // peripheral index
  input wire logic [pir_pkg::SRC_W-1:0] fire_bits_i, // sources hit
  input wire logic ack_en_i, // core takes lines
  input wire logic [3:0] ack_wait_i, // core delay
  input wire logic core_req_i, // offered request
  input wire logic [4:0] core_line_i, // offered line
  output logic [pir_pkg::NUM_SYS-1:0][pir_pkg::SRC_W-1:0] sys_event_o, // system
  output logic [pir_pkg::NUM_SERIAL-1:0][pir_pkg::SRC_W-1:0] serial_event_o, // serial
  output logic [pir_pkg::NUM_TIMER-1:0][pir_pkg::SRC_W-1:0] timer_event_o, // timers
  output logic [pir_pkg::SRC_W-1:0] adc_event_o, // converter
  output logic [pir_pkg::SRC_W-1:0] comparator_event_o, // comparator
  output logic core_ack_o, // take pulse
  output logic [4:0] core_ack_line_o // taken line
);
  logic [3:0] wait_q;
  // one-cycle pulse on the addressed peripheral only
  always_comb
  begin
    sys_event_o = '0;
    serial_event_o = '0;
    timer_event_o = '0;
    adc_event_o = (fire_i && fire_idx_i == 5'h15) ? fire_bits_i : '0;
    comparator_event_o = (fire_i && fire_idx_i == 5'h16) ? fire_bits_i : '0;
    if (fire_i && fire_idx_i < 5'h07) sys_event_o[fire_idx_i[2:0]] = fire_bits_i;
    if (fire_i && fire_idx_i inside {[5'h07:5'h0C]})
      serial_event_o[3'(fire_idx_i - 5'h07)] = fire_bits_i;
    if (fire_i && fire_idx_i inside {[5'h0D:5'h14]})
      timer_event_o[3'(fire_idx_i - 5'h0D)] = fire_bits_i;
  end
  // core waits ack_wait_i cycles; line is scrambled when not taking
  assign core_ack_o = ack_en_i && core_req_i && wait_q == ack_wait_i;
  assign core_ack_line_o = core_ack_o ? core_line_i : ~core_line_i;
  always_ff @(posedge clock_i)
    wait_q <= (!rst_b_i || !ack_en_i || !core_req_i || core_ack_o) ? 4'h0 : wait_q + 4'h1;
endmodule

// file: pir_pkg.sv
// peripheral interrupt routing: shared constants, register map and line mapping
// assumes a single 200 MHz clock domain and an APB register port with 12 address bits
package pir_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 23;
  localparam int SRC_W = 8;
  localparam int PRIO_W = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_PRIO_REGS = 8;
  localparam int NUM_SYS = 7;
  localparam int NUM_SERIAL = 6;
  localparam int NUM_TIMER = 8;

  typedef logic [4:0] pir_line_t;
  typedef logic [PRIO_W-1:0] pir_prio_t;

  // ----------------------------------------------------------------
  // line numbers of the peripherals
  // ----------------------------------------------------------------
  localparam int LINE_POWER_MANAGER = 0;
  localparam int LINE_SYSTEM_CONTROL = 1;
  localparam int LINE_WATCHDOG = 2;
  localparam int LINE_REAL_TIME_COUNTER = 3;
  localparam int LINE_EXT_PIN_UNIT = 4;
  localparam int LINE_FLASH_CONTROLLER = 5;
  localparam int LINE_EVENT_SYSTEM = 6;
  localparam int LINE_SERIAL_BASE = 7;
  localparam int LINE_TIMER_BASE = 13;
  localparam int LINE_ADC = 21;
  localparam int LINE_COMPARATOR = 22;

  // ----------------------------------------------------------------
  // controller registers (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_LINE_ENABLE_SET = 12'h000;
  localparam logic [11:0] OFS_LINE_ENABLE_CLEAR = 12'h004;
  localparam logic [11:0] OFS_PENDING_SET = 12'h008;
  localparam logic [11:0] OFS_PENDING_CLEAR = 12'h00C;
  localparam logic [11:0] OFS_PRIO_BASE = 12'h010;
  localparam logic [11:0] OFS_PRIO_LAST = 12'h02C;
  localparam logic [11:0] OFS_IRQ_STATUS = 12'h030;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h034;
  localparam logic [11:0] OFS_REQ_VIEW = 12'h038;

  // ----------------------------------------------------------------
  // per-peripheral register blocks: base + line * stride + offset
  // ----------------------------------------------------------------
  localparam logic [1:0] PERIPH_REGION = 2'h1;
  localparam logic [1:0] OFS_SOURCE_FLAG = 2'h0;
  localparam logic [1:0] OFS_SOURCE_ENABLE_SET = 2'h1;
  localparam logic [1:0] OFS_SOURCE_ENABLE_CLEAR = 2'h2;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [NUM_LINES-1:0] RST_LINES = 23'h000000;
  localparam logic [SRC_W-1:0] RST_SRC = 8'h00;
  localparam logic [PRIO_W-1:0] RST_PRIO = 2'h0;
  localparam logic [DATA_W-1:0] RST_DATA = 32'h00000000;

endpackage

// file: pir_top.sv
// peripheral interrupt routing: source flags, per-peripheral enables, line
// pending/enable/priority, arbitration towards the core and an APB port
// assumes all inputs synchronous to clock_i; event inputs are one-cycle pulses
//
// Decided for this implementation: the address map and the APB slave port.

module pir_top
  import pir_pkg::*;
(
  input wire logic clock_i, // 200 MHz clock
  input wire logic rst_b_i, // synchronous reset, active low
  input wire logic psel_i, // apb select
  input wire logic penable_i, // apb access phase
  input wire logic pwrite_i, // apb direction, high for write
  input wire logic [pir_pkg::ADDR_W-1:0] paddr_i, // apb byte address
  input wire logic [pir_pkg::DATA_W-1:0] pwdata_i, // apb write data
  output logic [pir_pkg::DATA_W-1:0] prdata_o, // apb read data
  output logic pready_o, // apb ready
  output logic pslverr_o, // apb error on unmapped address
  input wire logic [pir_pkg::NUM_SYS-1:0][pir_pkg::SRC_W-1:0] sys_event_i, // system events
  input wire logic [pir_pkg::NUM_SERIAL-1:0][pir_pkg::SRC_W-1:0] serial_event_i, // serial
  input wire logic [pir_pkg::NUM_TIMER-1:0][pir_pkg::SRC_W-1:0] timer_event_i, // timers
  input wire logic [pir_pkg::SRC_W-1:0] adc_event_i, // converter events
  input wire logic [pir_pkg::SRC_W-1:0] comparator_event_i, // comparator events
  input wire logic pin_nmi_i, // non-maskable level from pin unit
  input wire logic core_ack_i, // core takes the offered line
  input wire logic [4:0] core_ack_line_i, // line the core takes
  output logic nmi_o, // non-maskable request to core
  output logic core_req_o, // some line active
  output logic [4:0] core_line_o, // winning line
  output logic [pir_pkg::PRIO_W-1:0] core_prio_o, // winning priority
  output logic irq_o // summary interrupt from status and mask
);
  import pir_pkg::*;

  // ----------------------------------------------------------------
  // event routing onto numbered lines
  // ----------------------------------------------------------------
  logic [SRC_W-1:0] line_event [NUM_LINES];

  genvar gs;
  generate
    for (gs = 0; gs < NUM_SYS; gs++)
    begin : g_sys
      assign line_event[LINE_POWER_MANAGER + gs] = sys_event_i[gs];
    end
    for (gs = 0; gs < NUM_SERIAL; gs++)
    begin : g_ser
      assign line_event[LINE_SERIAL_BASE + gs] = serial_event_i[gs];
    end
    for (gs = 0; gs < NUM_TIMER; gs++)
    begin : g_tmr
      assign line_event[LINE_TIMER_BASE + gs] = timer_event_i[gs];
    end
  endgenerate
  assign line_event[LINE_ADC] = adc_event_i;
  assign line_event[LINE_COMPARATOR] = comparator_event_i;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic wr_acc;
  logic rd_setup;
  logic periph_hit;
  logic [4:0] periph_idx;
  logic [1:0] periph_ofs;
  logic ctrl_hit;
  logic prio_hit;
  logic [2:0] prio_idx;
  logic addr_ok;

  // writes act only on the access edge so a held setup cycle is harmless
  assign wr_acc = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
  assign periph_idx = paddr_i[8:4];
  assign periph_ofs = paddr_i[3:2];
  assign periph_hit = (paddr_i[11:10] == PERIPH_REGION) & ~paddr_i[9]
    & (periph_idx < 5'(NUM_LINES)) & (periph_ofs != 2'h3) & (paddr_i[1:0] == 2'h0);
  assign prio_hit = (paddr_i >= OFS_PRIO_BASE) & (paddr_i <= OFS_PRIO_LAST)
    & (paddr_i[1:0] == 2'h0);
  assign prio_idx = 3'(paddr_i[4:2] - 3'h4);
  assign ctrl_hit = (paddr_i[1:0] == 2'h0) & (paddr_i <= OFS_REQ_VIEW);
  assign addr_ok = periph_hit | ctrl_hit;

  // controller write strobes
  logic wr_len_set;
  logic wr_len_clr;
  logic wr_pend_set;
  logic wr_pend_clr;
  logic wr_status;
  logic wr_mask;
  assign wr_len_set = wr_acc & (paddr_i == OFS_LINE_ENABLE_SET);
  assign wr_len_clr = wr_acc & (paddr_i == OFS_LINE_ENABLE_CLEAR);
  assign wr_pend_set = wr_acc & (paddr_i == OFS_PENDING_SET);
  assign wr_pend_clr = wr_acc & (paddr_i == OFS_PENDING_CLEAR);
  assign wr_status = wr_acc & (paddr_i == OFS_IRQ_STATUS);
  assign wr_mask = wr_acc & (paddr_i == OFS_IRQ_MASK);

  // ----------------------------------------------------------------
  // per-peripheral flags and source enables
  // ----------------------------------------------------------------
  logic [SRC_W-1:0] flag_q [NUM_LINES];
  logic [SRC_W-1:0] flag_d [NUM_LINES];
  logic [SRC_W-1:0] src_en_q [NUM_LINES];
  logic [SRC_W-1:0] src_en_d [NUM_LINES];
  logic [NUM_LINES-1:0] periph_req;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_LINES; gp++)
    begin : g_periph
      logic sel;
      logic [SRC_W-1:0] flag_clr;
      logic [SRC_W-1:0] en_set;
      logic [SRC_W-1:0] en_clr;
      assign sel = wr_acc & periph_hit & (periph_idx == 5'(gp));
      assign flag_clr = (sel & (periph_ofs == OFS_SOURCE_FLAG)) ? pwdata_i[SRC_W-1:0] : RST_SRC;
      assign en_set = (sel & (periph_ofs == OFS_SOURCE_ENABLE_SET)) ?
        pwdata_i[SRC_W-1:0] : RST_SRC;
      assign en_clr = (sel & (periph_ofs == OFS_SOURCE_ENABLE_CLEAR)) ?
        pwdata_i[SRC_W-1:0] : RST_SRC;
      // a new event in the clearing cycle survives the clear
      assign flag_d[gp] = (flag_q[gp] & ~flag_clr) | line_event[gp];
      // set and clear live at different addresses so they never collide
      assign src_en_d[gp] = (src_en_q[gp] | en_set) & ~en_clr;
      // the request drops as soon as no enabled flag remains
      assign periph_req[gp] = |(flag_q[gp] & src_en_q[gp]);

      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
        begin
          flag_q[gp] <= RST_SRC;
          src_en_q[gp] <= RST_SRC;
        end
        else
        begin
          flag_q[gp] <= flag_d[gp];
          src_en_q[gp] <= src_en_d[gp];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // line pending, enable and priority
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] pend_q;
  logic [NUM_LINES-1:0] pend_d;
  logic [NUM_LINES-1:0] len_q;
  logic [NUM_LINES-1:0] len_d;
  logic [NUM_LINES-1:0] active;
  logic [NUM_LINES-1:0] ack_mask;
  pir_prio_t prio_q [NUM_LINES];
  logic [DATA_W-1:0] prio_word [NUM_PRIO_REGS];

  assign ack_mask = core_ack_i ? (NUM_LINES'(1) << core_ack_line_i) : RST_LINES;
  // a live request or software set wins over any clear in the same cycle
  assign pend_d = (pend_q & ~(wr_pend_clr ? pwdata_i[NUM_LINES-1:0] : RST_LINES) & ~ack_mask)
    | periph_req | (wr_pend_set ? pwdata_i[NUM_LINES-1:0] : RST_LINES);
  assign len_d = (len_q | (wr_len_set ? pwdata_i[NUM_LINES-1:0] : RST_LINES))
    & ~(wr_len_clr ? pwdata_i[NUM_LINES-1:0] : RST_LINES);
  assign active = pend_q & len_q;

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      pend_q <= RST_LINES;
      len_q <= RST_LINES;
    end
    else
    begin
      pend_q <= pend_d;
      len_q <= len_d;
    end
  end

  // four lines per priority word, field in the top bits of each byte
  genvar gl;
  generate
    for (gl = 0; gl < NUM_LINES; gl++)
    begin : g_prio
      logic hit;
      assign hit = wr_acc & prio_hit & (prio_idx == 3'(gl / 4));
      always_ff @(posedge clock_i)
      begin
        if (!rst_b_i)
          prio_q[gl] <= RST_PRIO;
        else if (hit)
          prio_q[gl] <= pwdata_i[(gl % 4) * 8 + 7 -: PRIO_W];
      end
    end
    for (gl = 0; gl < NUM_PRIO_REGS * 4; gl++)
    begin : g_prio_rd
      if (gl < NUM_LINES)
      begin : g_used
        assign prio_word[gl / 4][(gl % 4) * 8 +: 8] = {prio_q[gl], 6'h00};
      end
      else
      begin : g_unused
        assign prio_word[gl / 4][(gl % 4) * 8 +: 8] = 8'h00;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // arbitration towards the core: lowest value wins, ties to lowest line
  // ----------------------------------------------------------------
  logic best_vld;
  pir_line_t best_line;
  pir_prio_t best_prio;

  always_comb
  begin
    best_vld = 1'b0;
    best_line = 5'h00;
    best_prio = RST_PRIO;
    for (int i = 0; i < NUM_LINES; i++)
    begin
      if (active[i] && (!best_vld || prio_q[i] < best_prio))
      begin
        best_vld = 1'b1;
        best_line = 5'(i);
        best_prio = prio_q[i];
      end
    end
  end

  logic req_q;
  pir_line_t line_q;
  pir_prio_t prio_out_q;
  logic nmi_q;

  // registered offer; the nmi path bypasses lines and masks entirely
  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      req_q <= 1'b0;
      line_q <= 5'h00;
      prio_out_q <= RST_PRIO;
      nmi_q <= 1'b0;
    end
    else
    begin
      req_q <= best_vld;
      line_q <= best_line;
      prio_out_q <= best_prio;
      nmi_q <= pin_nmi_i;
    end
  end

  // ----------------------------------------------------------------
  // summary interrupt: sticky status on a line becoming active
  // ----------------------------------------------------------------
  logic [NUM_LINES-1:0] active_q;
  logic [NUM_LINES-1:0] status_q;
  logic [NUM_LINES-1:0] status_d;
  logic [NUM_LINES-1:0] mask_q;

  assign status_d = (status_q & ~(wr_status ? pwdata_i[NUM_LINES-1:0] : RST_LINES))
    | (active & ~active_q);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
    begin
      active_q <= RST_LINES;
      status_q <= RST_LINES;
      mask_q <= RST_LINES;
    end
    else
    begin
      active_q <= active;
      status_q <= status_d;
      if (wr_mask)
        mask_q <= pwdata_i[NUM_LINES-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read path: sampled in the setup cycle, returned in the access cycle
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] periph_rd;
  logic [DATA_W-1:0] ctrl_rd;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] prdata_q;

  assign periph_rd = {24'h000000, (periph_ofs == OFS_SOURCE_FLAG) ?
    flag_q[periph_idx] : src_en_q[periph_idx]};
  assign ctrl_rd =
    ((paddr_i == OFS_LINE_ENABLE_SET) | (paddr_i == OFS_LINE_ENABLE_CLEAR)) ? {9'h000, len_q} :
    ((paddr_i == OFS_PENDING_SET) | (paddr_i == OFS_PENDING_CLEAR)) ? {9'h000, pend_q} :
    prio_hit ? prio_word[prio_idx] :
    (paddr_i == OFS_IRQ_STATUS) ? {9'h000, status_q} :
    (paddr_i == OFS_IRQ_MASK) ? {9'h000, mask_q} :
    (paddr_i == OFS_REQ_VIEW) ? {9'h000, periph_req} : RST_DATA;
  assign rd_mux = periph_hit ? periph_rd : (ctrl_hit ? ctrl_rd : RST_DATA);

  always_ff @(posedge clock_i)
  begin
    if (!rst_b_i)
      prdata_q <= RST_DATA;
    else if (rd_setup)
      prdata_q <= rd_mux;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata_o = prdata_q;
  assign pready_o = 1'b1; // every access completes in its first access cycle
  assign pslverr_o = psel_i & penable_i & ~addr_ok;
  assign nmi_o = nmi_q;
  assign core_req_o = req_q;
  assign core_line_o = line_q;
  assign core_prio_o = prio_out_q;
  assign irq_o = |(status_q & mask_q);

endmodule

// file: pir_top_asserts.sv
// checker for the routing block, watching its top-level ports only
// assumes one clock domain; attached to every pir_top by the bind below
module pir_top_asserts
  import pir_pkg::*;
(
  input wire logic clock_i, // clock
  input wire logic rst_b_i, // reset, active low
  input wire logic psel_i, // select
  input wire logic penable_i, // access phase
  input wire logic pwrite_i, // write
  input wire logic [pir_pkg::ADDR_W-1:0] paddr_i, // address
  input wire logic [pir_pkg::DATA_W-1:0] prdata_o, // read data
  input wire logic pready_o, // ready
  input wire logic pslverr_o, // error
  input wire logic pin_nmi_i, // pin nmi
  input wire logic nmi_o, // core nmi
  input wire logic core_req_o, // request
  input wire logic [4:0] core_line_o, // line
  input wire logic irq_o // summary irq
);
  // --------------------------------
  // own copy of the map
  // --------------------------------
  // kept apart from the design so a decode slip cannot hide itself
  wire logic acc = psel_i && penable_i;
  wire logic algn = paddr_i[1:0] == 2'h0;
  wire logic hit = paddr_i <= 12'h038 || (paddr_i >= 12'h400 && paddr_i < 12'h570
    && paddr_i[3:2] != 2'h3);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  // --------------------------------
  // properties
  // --------------------------------
  a_ready_high: assert property (pready_o) else $error("ready low");
  a_nmi_follow: assert property ($past(rst_b_i) |-> nmi_o == $past(pin_nmi_i))
    else $error("nmi not one cycle behind pin");
  a_unaligned_err: assert property (acc && !algn |-> pslverr_o)
    else $error("unaligned access accepted");
  a_hole_err: assert property (acc && algn && !hit |-> pslverr_o)
    else $error("hole access accepted");
  a_mapped_ok: assert property (acc && algn && hit |-> !pslverr_o)
    else $error("mapped access refused");
  a_err_readzero: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
    else $error("refused read not zero");
  a_rdata_hold: assert property (!(psel_i && !penable_i) |=> $stable(prdata_o))
    else $error("read data moved outside setup");
  a_quiet_reset: assert property ($rose(rst_b_i) |-> !core_req_o && !irq_o && !nmi_o)
    else $error("outputs not quiet after reset");
  a_line_range: assert property (core_req_o |-> core_line_o <= 5'h16)
    else $error("line out of range");
  c_last_line: cover property (core_req_o && core_line_o == 5'h16);
  c_irq: cover property (irq_o);
  c_nmi: cover property (nmi_o);
  c_err: cover property (acc && pslverr_o);
endmodule

bind pir_top pir_top_asserts pir_top_asserts_inst (.clock_i, .rst_b_i, .psel_i, .penable_i,
  .pwrite_i, .paddr_i, .prdata_o, .pready_o, .pslverr_o, .pin_nmi_i, .nmi_o, .core_req_o,
  .core_line_o, .irq_o);

// file: tb_pir_top.sv
// self-checking bench for the routing block with its far-side model
// assumes the checker is bound to the design; one 200 MHz clock
module tb_pir_top
  import pir_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, rst_b_i, psel, penable, pwrite, pready, pslverr, pin_nmi, nmi, core_req;
  logic core_ack, irq, fire, ack_en;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [4:0] fire_idx, core_line, ack_line;
  logic [SRC_W-1:0] fire_bits, adc_ev, cmp_ev;
  logic [3:0] ack_wait;
  logic [PRIO_W-1:0] core_prio;
  logic [NUM_SYS-1:0][SRC_W-1:0] sys_ev;
  logic [NUM_SERIAL-1:0][SRC_W-1:0] ser_ev;
  logic [NUM_TIMER-1:0][SRC_W-1:0] tmr_ev;
  int n_mismatch = 0;
  int cmp_count = 0;
  pir_top pir_top_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sys_event_i(sys_ev), .serial_event_i(ser_ev), .timer_event_i(tmr_ev),
    .adc_event_i(adc_ev), .comparator_event_i(cmp_ev), .pin_nmi_i(pin_nmi), .core_ack_i(core_ack),
    .core_ack_line_i(ack_line), .nmi_o(nmi), .core_req_o(core_req), .core_line_o(core_line),
    .core_prio_o(core_prio), .irq_o(irq));
  pir_far_model pir_far_model_inst (.clock_i(clock_i), .rst_b_i(rst_b_i), .fire_i(fire),
    .fire_idx_i(fire_idx), .fire_bits_i(fire_bits), .ack_en_i(ack_en), .ack_wait_i(ack_wait),
    .core_req_i(core_req), .core_line_i(core_line), .sys_event_o(sys_ev),
    .serial_event_o(ser_ev), .timer_event_o(tmr_ev), .adc_event_o(adc_ev),
    .comparator_event_o(cmp_ev), .core_ack_o(core_ack), .core_ack_line_o(ack_line));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic end_sim();
    if (n_mismatch == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t word %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("ERROR %0t flag %b want %b", $time, got, exp);
    end
  endtask
  // apb cycle; an idle edge first so psel is never assigned twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    @(posedge clock_i);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, exp);
  endtask
  function automatic logic [11:0] pa(input int p, input int o);
    return 12'h400 + 12'(p * 16 + o * 4);
  endfunction
  task automatic fire_ev(input int p, input logic [7:0] b);
    @(posedge clock_i);
    {fire, fire_idx, fire_bits} <= {1'b1, 5'(p), b};
    @(posedge clock_i);
    fire <= 1'b0;
  endtask
  // --------------------------------
  // scenarios
  // --------------------------------
  task automatic t_source();
    fire_ev(3, 8'h04);
    rd_chk(pa(3, 0), 32'h4);
    rd_chk(12'h038, 32'h0);
    wr(pa(3, 1), 32'h24);
    wr(pa(3, 1), 32'h0);
    rd_chk(pa(3, 1), 32'h24);
    rd_chk(12'h038, 32'h8);
    rd_chk(12'h008, 32'h8);
    fire_ev(3, 8'h20);
    wr(pa(3, 2), 32'h04);
    rd_chk(pa(3, 2), 32'h20);
    rd_chk(12'h038, 32'h8);
    wr(pa(3, 0), 32'h0);
    rd_chk(pa(3, 0), 32'h24);
    wr(pa(3, 0), 32'h20);
    rd_chk(12'h038, 32'h0);
  endtask
  task automatic t_mapping();
    wr(12'h00C, 32'h7FFFFF);
    wr(12'h000, 32'h7FFFFF);
    for (int p = 0; p < NUM_LINES; p++)
    begin
      wr(pa(p, 1), 32'h1);
      fire_ev(p, 8'h01);
      repeat (3) @(posedge clock_i);
      chk1(core_req, 1'b1);
      chk32({27'h0, core_line}, 32'(p));
      wr(pa(p, 0), 32'h1);
      wr(12'h00C, 32'h1 << p);
    end
    repeat (2) @(posedge clock_i);
    chk1(core_req, 1'b0);
  endtask
  task automatic t_pending();
    wr(12'h004, 32'h7FFFFF);
    wr(12'h008, 32'h200);
    rd_chk(12'h008, 32'h200);
    chk1(core_req, 1'b0);
    wr(12'h000, 32'h200);
    rd_chk(12'h004, 32'h200);
    chk32({27'h0, core_line}, 32'h9);
    chk1(core_req, 1'b1);
    wr(12'h00C, 32'h200);
    rd_chk(12'h008, 32'h0);
    chk1(core_req, 1'b0);
  endtask
  task automatic t_priority();
    for (int k = 0; k < 5; k++)
    begin
      wr(12'h010 + 12'(4 * k), 32'hFFFFFFFF);
      rd_chk(12'h010 + 12'(4 * k), 32'hC0C0C0C0);
    end
    wr(12'h008, 32'h200002);
    wr(12'h000, 32'h200002);
    repeat (3) @(posedge clock_i);
    chk32({25'h0, core_line, 2'(core_prio)}, {25'h0, 5'h15, 2'h0});
    wr(12'h024, 32'hC000);
    repeat (3) @(posedge clock_i);
    chk32({25'h0, core_line, 2'(core_prio)}, {25'h0, 5'h01, 2'h3});
    wr(12'h00C, 32'h200002);
    wr(12'h004, 32'h200002);
  endtask
  // slow core takes line 12; status and mask then drive irq
  task automatic t_ack_irq();
    wr(12'h030, 32'h7FFFFF);
    {ack_en, ack_wait} <= {1'b1, 4'h3};
    wr(12'h000, 32'h1000);
    wr(12'h008, 32'h1000);
    repeat (12) @(posedge clock_i);
    rd_chk(12'h008, 32'h0);
    rd_chk(12'h030, 32'h1000);
    chk1(irq, 1'b0);
    wr(12'h034, 32'h1000);
    rd_chk(12'h034, 32'h1000);
    chk1(irq, 1'b1);
    wr(12'h030, 32'h1000);
    rd_chk(12'h030, 32'h0);
    chk1(irq, 1'b0);
    ack_en <= 1'b0;
  endtask
  task automatic t_nmi_err();
    logic [31:0] r;
    logic e;
    @(posedge clock_i);
    pin_nmi <= 1'b1;
    repeat (2) @(posedge clock_i);
    chk1(nmi, 1'b1);
    chk1(core_req, 1'b0);
    pin_nmi <= 1'b0;
    apb(1'b0, 12'h03C, 32'h0, r, e);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    apb(1'b1, 12'h40C, 32'hFF, r, e);
    chk1(e, 1'b1);
    // unaligned read must be refused and return zero
    apb(1'b0, 12'h002, 32'h0, r, e);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    chk1(nmi, 1'b0);
  endtask
  // --------------------------------
  // run
  // --------------------------------
  initial
  begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  initial
  begin
    #50000;
    n_mismatch++;
    end_sim();
  end
  initial
  begin
    {rst_b_i, psel, penable, pwrite, paddr, pwdata, pin_nmi, fire, ack_en} = '0;
    {fire_idx, fire_bits, ack_wait} = '0;
    repeat (6) @(posedge clock_i);
    rst_b_i <= 1'b1;
    t_source();
    t_mapping();
    t_pending();
    t_priority();
    t_ack_irq();
    t_nmi_err();
    end_sim();
  end
endmodule
